// ===== design/diag_consts.vh
// Register indices, reset values, field positions and codes for the diagnostics
`ifndef DIAG_CONSTS_VH
`define DIAG_CONSTS_VH

`define IDX_MODE        10'h0170
`define IDX_PULSE       10'h0171
`define IDX_LISTEN      10'h0173
`define IDX_SHORT       10'h0177
`define IDX_LOC_A       10'h0180
`define IDX_LOC_B       10'h0181
`define IDX_LOC_C       10'h0182
`define IDX_RUN         10'h001e
`define IDX_IRQ_STAT    10'h0190
`define IDX_IRQ_MASK    10'h0191

`define MODE_RST        16'h0e00
`define MODE_WMASK      16'h6f00
`define PULSE_RST       16'hc851
`define LISTEN_RST      16'ha01e
`define SHORT_RST       16'h0d96

`define CROSS_DIS_BIT   14
`define TX_BYP_BIT      13
`define RX_BYP_BIT      12
`define AVG_MSB         10
`define AVG_LSB         8
`define AVG_MAX_CODE    3'h6

`define RUN_START_BIT   0
`define RUN_DONE_BIT    1
`define IRQ_DONE_BIT    0

`define PAIR_TX         1'b0
`define PAIR_RX         1'b1

`endif

// ===== design/tdr_cycle_counter.v
// Counts averaged measurement cycles for one pair
`timescale 1ns/1ns
module tdr_cycle_counter #(
  parameter CNT_W = 7
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             clear,
  input  wire             step,
  input  wire [2:0]       code,
  output wire             last
);

  reg  [CNT_W-1:0] count_q;
  wire [CNT_W-1:0] target;

  // Code n means 2**n cycles; count runs 0 .. 2**n - 1
  assign target = ({{(CNT_W-1){1'b0}}, 1'b1} << code) -
                  {{(CNT_W-1){1'b0}}, 1'b1};
  assign last   = (count_q == target);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= {CNT_W{1'b0}};
    end else if (clear) begin
      count_q <= {CNT_W{1'b0}};
    end else if (step) begin
      count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// ===== design/peak_averager.v
// Accumulates peak locations over several cycles and divides by a power of 2
`timescale 1ns/1ns
module peak_averager #(
  parameter PEAKS = 5,
  parameter LOC_W = 8,
  parameter SUM_W = 14
) (
  input  wire                   clk,
  input  wire                   rst_n,
  input  wire                   clear,
  input  wire                   add,
  input  wire [PEAKS*LOC_W-1:0] peaks,
  input  wire [2:0]             shift,
  output wire [PEAKS*LOC_W-1:0] avg
);

  genvar g;

  generate
    for (g = 0; g < PEAKS; g = g + 1) begin : lane
      // One sum per lane keeps every flop with a single driver
      reg  [SUM_W-1:0] sum_q;
      wire [SUM_W-1:0] quot;
      // Sum is wide enough for 64 full-scale samples, so no overflow
      assign quot = sum_q >> shift;
      assign avg[g*LOC_W +: LOC_W] = quot[LOC_W-1:0];
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sum_q <= {SUM_W{1'b0}};
        end else if (clear) begin
          sum_q <= {SUM_W{1'b0}};
        end else if (add) begin
          sum_q <= sum_q +
                   {{(SUM_W-LOC_W){1'b0}}, peaks[g*LOC_W +: LOC_W]};
        end
      end
    end
  endgenerate

endmodule

// ===== design/cable_tdr_diag_regs.v
// Cable reflectometry diagnostic registers, sequencer and AHB-Lite slave
`timescale 1ns/1ns
`include "diag_consts.vh"
module cable_tdr_diag_regs #(
  parameter ADDR_W = 12,
  parameter PEAKS  = 5,
  parameter LOC_W  = 8
) (
  input  wire                   hclk,
  input  wire                   hresetn,
  input  wire                   hsel,
  input  wire [ADDR_W-1:0]      haddr,
  input  wire [1:0]             htrans,
  input  wire                   hwrite,
  input  wire [2:0]             hsize,
  input  wire                   hready,
  input  wire [31:0]            hwdata,
  output reg  [31:0]            hrdata,
  output reg                    hreadyout,
  output reg                    hresp,
  output reg                    irq,
  output reg                    meas_req,
  output reg                    meas_pair,
  output reg                    meas_cross,
  output wire [3:0]             meas_pulse,
  output wire [7:0]             meas_listen,
  output wire [4:0]             meas_short_th,
  input  wire                   meas_ack,
  input  wire [PEAKS*LOC_W-1:0] meas_peaks
);

  //////////////////////////////////////////////////////////////////////////
  // State and register storage

  localparam ST_IDLE = 3'd0;
  localparam ST_REQ  = 3'd1;
  localparam ST_WAIT = 3'd2;
  localparam ST_LOAD = 3'd3;
  localparam ST_DONE = 3'd4;

  reg  [2:0]            st_q;
  reg  [2:0]            st_d;
  reg  [15:0]           mode_q;
  reg  [15:0]           pulse_q;
  reg  [15:0]           listen_q;
  reg  [15:0]           short_q;
  reg  [15:0]           loc_a_q;
  reg  [15:0]           loc_b_q;
  reg  [15:0]           loc_c_q;
  reg                   done_q;
  reg                   irq_stat_q;
  reg                   irq_mask_q;
  reg  [2:0]            avg_code_q;
  reg                   tx_byp_run_q;

  reg                   wr_pend_q;
  reg                   rd_pend_q;
  reg  [ADDR_W-3:0]     idx_q;

  wire                  busy;
  wire                  accept;
  wire                  wr_en;
  wire                  start;
  wire                  finish;
  wire                  avg_clear;
  wire                  avg_add;
  wire                  last_cycle;
  wire [PEAKS*LOC_W-1:0] avg;
  wire [2:0]            code_sel;
  wire                  wr_run;
  wire                  wr_stat;
  wire                  wr_mask;
  wire                  load_tx;

  assign busy   = (st_q != ST_IDLE);
  assign accept = hsel & htrans[1] & hready;
  assign wr_en  = wr_pend_q;

  // Start only while idle; a start during a run is dropped rather than
  // queued, so software waits for done before it starts again
  assign wr_run  = wr_en & (idx_q == `IDX_RUN);
  assign wr_stat = wr_en & (idx_q == `IDX_IRQ_STAT);
  assign wr_mask = wr_en & (idx_q == `IDX_IRQ_MASK);
  assign start   = wr_run & hwdata[`RUN_START_BIT] & ~busy;
  assign finish  = (st_q == ST_DONE);
  // Leaving the transmit pass also clears the sums for the receive pass
  assign load_tx = (st_q == ST_LOAD) & (meas_pair == `PAIR_TX);

  // Reserved code 111 runs as 64 cycles rather than as an undefined count
  assign code_sel = (mode_q[`AVG_MSB:`AVG_LSB] > `AVG_MAX_CODE) ?
                    `AVG_MAX_CODE : mode_q[`AVG_MSB:`AVG_LSB];

  assign avg_clear = start | load_tx;
  assign avg_add   = (st_q == ST_WAIT) & meas_ack;

  // Analog settings come straight from the configuration flops
  assign meas_pulse    = pulse_q[3:0];
  assign meas_listen   = listen_q[15:8];
  assign meas_short_th = short_q[12:8];

  //////////////////////////////////////////////////////////////////////////
  // Read decode

  function [15:0] read_mux;
    input [ADDR_W-3:0] idx;
    begin
      case (idx)
        `IDX_MODE:     read_mux = mode_q;
        `IDX_PULSE:    read_mux = pulse_q;
        `IDX_LISTEN:   read_mux = listen_q;
        `IDX_SHORT:    read_mux = short_q;
        `IDX_LOC_A:    read_mux = loc_a_q;
        `IDX_LOC_B:    read_mux = loc_b_q;
        `IDX_LOC_C:    read_mux = loc_c_q;
        `IDX_RUN:      read_mux = {14'h0000, done_q, busy};
        `IDX_IRQ_STAT: read_mux = {15'h0000, irq_stat_q};
        `IDX_IRQ_MASK: read_mux = {15'h0000, irq_mask_q};
        default:       read_mux = 16'h0000;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero-wait writes, one wait state on reads

  // The wait state lets a write in the previous data phase land before the
  // read is sampled, and keeps hrdata a plain flop
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q     <= {(ADDR_W-2){1'b0}};
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      wr_pend_q <= accept & hwrite;
      rd_pend_q <= accept & ~hwrite;
      if (accept) begin
        idx_q <= haddr[ADDR_W-1:2];
      end
      if (accept & ~hwrite) begin
        hreadyout <= 1'b0;
      end else if (rd_pend_q) begin
        hreadyout <= 1'b1;
        hrdata    <= {16'h0000, read_mux(idx_q)};
      end
      hresp <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Configuration registers
  // Analog settings follow writes at once, even in the middle of a run

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q   <= `MODE_RST;
      pulse_q  <= `PULSE_RST;
      listen_q <= `LISTEN_RST;
      short_q  <= `SHORT_RST;
    end else if (wr_en) begin
      case (idx_q)
        `IDX_MODE: begin
          // Bits 15, 12 and 7:0 hold their value whatever is written
          mode_q <= (hwdata[15:0] & `MODE_WMASK) |
                    (`MODE_RST & ~`MODE_WMASK);
        end
        `IDX_PULSE: begin
          pulse_q <= hwdata[15:0];
        end
        `IDX_LISTEN: begin
          listen_q <= hwdata[15:0];
        end
        `IDX_SHORT: begin
          short_q <= hwdata[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= 1'b0;
      irq_mask_q <= 1'b0;
      irq        <= 1'b0;
    end else begin
      // A completion in the same cycle as a clear keeps the bit set
      if (finish) begin
        irq_stat_q <= 1'b1;
      end else if (wr_stat & hwdata[`IRQ_DONE_BIT]) begin
        irq_stat_q <= 1'b0;
      end
      if (wr_mask) begin
        irq_mask_q <= hwdata[`IRQ_DONE_BIT];
      end
      irq <= irq_stat_q & irq_mask_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Measurement sequencer
  // Pair, cross mode and cycle code are latched at start, so writes made
  // during a run cannot change what is being averaged

  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (start) begin
          st_d = ST_REQ;
        end
      end
      ST_REQ: begin
        st_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (meas_ack) begin
          st_d = last_cycle ? ST_LOAD : ST_REQ;
        end
      end
      ST_LOAD: begin
        st_d = (meas_pair == `PAIR_TX) ? ST_REQ : ST_DONE;
      end
      ST_DONE: begin
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q         <= ST_IDLE;
      meas_req     <= 1'b0;
      meas_pair    <= `PAIR_TX;
      meas_cross   <= 1'b0;
      avg_code_q   <= 3'h0;
      tx_byp_run_q <= 1'b0;
      done_q       <= 1'b0;
    end else begin
      st_q     <= st_d;
      meas_req <= (st_d == ST_REQ);
      if (start) begin
        done_q       <= 1'b0;
        avg_code_q   <= code_sel;
        tx_byp_run_q <= mode_q[`TX_BYP_BIT];
        // Skip the transmit pair when it is bypassed
        meas_pair    <= mode_q[`TX_BYP_BIT] ? `PAIR_RX :
                        `PAIR_TX;
        // Cross mode makes the front end watch the opposite pair
        meas_cross   <= ~mode_q[`CROSS_DIS_BIT];
      end else if (load_tx) begin
        // Receive pair is never bypassed since its bypass bit is fixed
        meas_pair <= `PAIR_RX;
      end
      if (finish) begin
        done_q <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Result registers
  // Locations change only at load; reads during a run show the last run until the first pass loads (the receive pass when transmit is bypassed)

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loc_a_q <= 16'h0000;
      loc_b_q <= 16'h0000;
      loc_c_q <= 16'h0000;
    end else if (st_q == ST_LOAD) begin
      if (meas_pair == `PAIR_TX) begin
        // Lowest peak number in the low byte
        loc_a_q      <= avg[15:0];
        loc_b_q      <= avg[31:16];
        loc_c_q[7:0] <= avg[39:32];
      end else begin
        loc_c_q[15:8] <= avg[7:0];
        if (tx_byp_run_q) begin
          // Bypassed pair leaves its own slots empty
          loc_a_q      <= 16'h0000;
          loc_b_q      <= 16'h0000;
          loc_c_q[7:0] <= 8'h00;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Averaging datapath
  // Counter and sums share one clear, so they cannot drift apart

  tdr_cycle_counter #(
    .CNT_W (7)
  ) u_cycles (
    .clk   (hclk),
    .rst_n (hresetn),
    .clear (avg_clear),
    .step  (avg_add),
    .code  (avg_code_q),
    .last  (last_cycle)
  );

  peak_averager #(
    .PEAKS (PEAKS),
    .LOC_W (LOC_W),
    .SUM_W (14)
  ) u_avg (
    .clk   (hclk),
    .rst_n (hresetn),
    .clear (avg_clear),
    .add   (avg_add),
    .peaks (meas_peaks),
    .shift (avg_code_q),
    .avg   (avg)
  );

endmodule

// ===== test/cable_tdr_diag_regs_chk.sv
// Port checker for the cable diagnostic register block
`timescale 1ns/1ns
`include "diag_consts.vh"
module cable_tdr_diag_regs_chk #(
  parameter ADDR_W = 12
) (
  input wire              hclk,
  input wire              hresetn,
  input wire              hsel,
  input wire [ADDR_W-1:0] haddr,
  input wire [1:0]        htrans,
  input wire              hwrite,
  input wire              hready,
  input wire [31:0]       hwdata,
  input wire [31:0]       hrdata,
  input wire              hreadyout,
  input wire              hresp,
  input wire              meas_req,
  input wire              meas_pair,
  input wire              meas_cross,
  input wire [3:0]        meas_pulse,
  input wire [7:0]        meas_listen,
  input wire [4:0]        meas_short_th,
  input wire              meas_ack
);
  wire             take = hsel && htrans[1] && hready;
  reg              wph_q, rph_q, cdis_q, byp_q;
  reg [ADDR_W-3:0] idx_q;
  reg [3:0]        pls_q;
  // Shadows of written fields, rebuilt from bus traffic alone
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wph_q  <= 1'b0;
      rph_q  <= 1'b0;
      idx_q  <= '0;
      pls_q  <= 4'h1;
      cdis_q <= 1'b0;
      byp_q  <= 1'b0;
    end else begin
      wph_q <= take && hwrite;
      rph_q <= take && !hwrite;
      if (take) idx_q <= haddr[ADDR_W-1:2];
      if (wph_q && idx_q == `IDX_PULSE) pls_q <= hwdata[3:0];
      if (wph_q && idx_q == `IDX_MODE) begin
        cdis_q <= hwdata[14];
        byp_q  <= hwdata[13];
      end
    end
  end
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);
  rd_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  wr_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write waited");
  bus_okay_a: assert property (!hresp)
    else $error("error response");
  mode_read_a: assert property (
    rph_q && idx_q == `IDX_MODE |=> hrdata[15] == 1'b0
      && hrdata[12] == 1'b0 && hrdata[7:0] == 8'h00 && hrdata[11]
  ) else $error("mode bits wrong");
  rst_vals_a: assert property (
    $rose(hresetn) |-> meas_pulse == 4'h1 && meas_listen == 8'ha0
      && meas_short_th == 5'h0d && !meas_req
  ) else $error("settings wrong after reset");
  pulse_follow_a: assert property (
    wph_q && idx_q == `IDX_PULSE |=> ##[0:1] meas_pulse == pls_q
  ) else $error("pulse not applied");
  cross_mode_a: assert property (
    meas_req |-> meas_cross == !cdis_q
  ) else $error("cross mode wrong");
  tx_bypass_a: assert property (
    meas_req && byp_q |-> meas_pair
  ) else $error("bypassed pair measured");
  req_pulse_a: assert property (
    meas_req |=> !meas_req
  ) else $error("request too long");
endmodule
bind cable_tdr_diag_regs cable_tdr_diag_regs_chk #(.ADDR_W(ADDR_W)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .meas_req(meas_req), .meas_pair(meas_pair), .meas_cross(meas_cross),
  .meas_pulse(meas_pulse), .meas_listen(meas_listen),
  .meas_short_th(meas_short_th), .meas_ack(meas_ack)
);

// ===== test/tdr_front_end_model.sv
// Behavioural cable front end answering measurement requests
`timescale 1ns/1ns
module tdr_front_end_model (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        meas_req,
  input  wire        meas_pair,
  input  wire        slow,
  output reg         meas_ack,
  output reg  [39:0] meas_peaks
);
  reg       pend_q, pair_q, alt_q;
  reg [2:0] lag_q;
  integer   i;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q     <= 1'b0;
      pair_q     <= 1'b0;
      alt_q      <= 1'b0;
      lag_q      <= 3'h0;
      meas_ack   <= 1'b0;
      meas_peaks <= 40'h00_0000_0000;
    end else begin
      meas_ack   <= 1'b0;
      // Idle lines toggle so a stale value never passes for a result
      meas_peaks <= ~meas_peaks;
      if (meas_req) begin
        pend_q <= 1'b1;
        pair_q <= meas_pair;
        lag_q  <= slow ? 3'h4 : 3'h0;
      end else if (pend_q && lag_q != 3'h0) begin
        lag_q <= lag_q - 3'h1;
      end else if (pend_q) begin
        pend_q   <= 1'b0;
        meas_ack <= 1'b1;
        alt_q    <= ~alt_q;
        for (i = 0; i < 5; i = i + 1)
          meas_peaks[8*i +: 8] <= (pair_q ? 8'h21 : 8'h11) + 8'(i)
            + {6'h00, alt_q, 1'b0};
      end
    end
  end
endmodule

// ===== test/tb_cable_tdr_diag_regs.sv
// Self-checking bench for the cable diagnostic register block
`timescale 1ns/1ns
`include "diag_consts.vh"
module tb_cable_tdr_diag_regs;
  logic        hclk, hresetn, hsel, hwrite, slow;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, irq, meas_req, meas_pair, meas_ack;
  wire  [39:0] meas_peaks;
  int          fail_count, cmp_count, n_tx, n_rx;

  cable_tdr_diag_regs dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq), .meas_req(meas_req), .meas_pair(meas_pair),
    .meas_cross(), .meas_pulse(), .meas_listen(), .meas_short_th(),
    .meas_ack(meas_ack), .meas_peaks(meas_peaks)
  );
  tdr_front_end_model cable (
    .hclk(hclk), .hresetn(hresetn), .meas_req(meas_req),
    .meas_pair(meas_pair), .slow(slow), .meas_ack(meas_ack),
    .meas_peaks(meas_peaks)
  );
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (meas_req === 1'b1 && meas_pair === 1'b1) n_rx++;
    else if (meas_req === 1'b1) n_tx++;
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin @(posedge hclk); n++; end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      fail_count++;
      report_and_stop;
    end
  endtask
  // Address phase held until ready, then data phase held until ready
  task automatic xfer(input logic w, input logic [9:0] i,
                      input logic [15:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= {i, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy;
    htrans <= 2'b00;
    hwdata <= {16'h0000, d};
    wait_rdy;
    r = hrdata;
  endtask
  task automatic wr(input logic [9:0] i, input logic [15:0] d);
    logic [31:0] r;
    xfer(1'b1, i, d, r);
  endtask
  task automatic rd(input string nm, input logic [9:0] i, logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, i, 16'h0000, r);
    chk(nm, e, r);
  endtask
  task automatic t_reset;
    rd("mode", `IDX_MODE, 32'h0000_0e00);
    rd("pulse", `IDX_PULSE, 32'h0000_c851);
    rd("listen", `IDX_LISTEN, 32'h0000_a01e);
    rd("short", `IDX_SHORT, 32'h0000_0d96);
    rd("loc_a", `IDX_LOC_A, 32'h0000_0000);
    rd("loc_b", `IDX_LOC_B, 32'h0000_0000);
    rd("loc_c", `IDX_LOC_C, 32'h0000_0000);
    $display("test reset values done");
  endtask
  task automatic t_access;
    wr(`IDX_MODE, 16'hffff);
    rd("mode", `IDX_MODE, 32'h0000_6f00);
    wr(`IDX_PULSE, 16'h3a5c);
    rd("pulse", `IDX_PULSE, 32'h0000_3a5c);
    wr(`IDX_LISTEN, 16'h5ac3);
    rd("listen", `IDX_LISTEN, 32'h0000_5ac3);
    wr(`IDX_SHORT, 16'hb27e);
    rd("short", `IDX_SHORT, 32'h0000_b27e);
    wr(`IDX_LOC_A, 16'hffff);
    rd("loc_a", `IDX_LOC_A, 32'h0000_0000);
    wr(10'h3ff, 16'hffff);
    rd("unmapped", 10'h3ff, 32'h0000_0000);
    $display("test access kinds done");
  endtask
  // Locations of zero mean the run is judged on counts and interrupt only
  task automatic t_run(input logic [15:0] m, input logic k, input int ex,
                       er, input logic [47:0] loc);
    logic [31:0] r;
    int n;
    wr(`IDX_MODE, m);
    wr(`IDX_IRQ_MASK, {15'h0000, k});
    n_tx = 0;
    n_rx = 0;
    wr(`IDX_RUN, 16'h0001);
    n = 0;
    do begin xfer(1'b0, `IDX_RUN, 16'h0000, r); n++; end
    while (r[1] !== 1'b1 && n < 1000);
    if (r[1] !== 1'b1) begin
      fail_count++;
      report_and_stop;
    end
    chk("tx count", ex, n_tx);
    chk("rx count", er, n_rx);
    if (loc != 48'h0000_0000_0000) begin
      rd("loc_a", `IDX_LOC_A, {16'h0000, loc[47:32]});
      rd("loc_b", `IDX_LOC_B, {16'h0000, loc[31:16]});
      rd("loc_c", `IDX_LOC_C, {16'h0000, loc[15:0]});
    end
    rd("irq status", `IDX_IRQ_STAT, 32'h0000_0001);
    chk("irq", {31'h0000_0000, k}, {31'h0000_0000, irq});
    wr(`IDX_IRQ_STAT, 16'h0001);
    rd("irq status", `IDX_IRQ_STAT, 32'h0000_0000);
    chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
    $display("test run mode %h done", m);
  endtask
  initial begin
    hresetn    = 1'b0;
    hsel       = 1'b0;
    haddr      = 12'h000;
    htrans     = 2'b00;
    hwrite     = 1'b0;
    hwdata     = 32'h0000_0000;
    slow       = 1'b0;
    fail_count = 0;
    cmp_count  = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_access;
    t_run(16'h0900, 1'b1, 2, 2, 48'h1312_1514_2216);
    slow <= 1'b1;
    t_run(16'h2a00, 1'b1, 0, 4, 48'h0000_0000_2200);
    slow <= 1'b0;
    t_run(16'h4800, 1'b0, 1, 1, 48'h1211_1413_2315);
    // Reserved code 7 runs as the largest count
    for (int c = 0; c < 8; c++) begin
      int e;
      e = 1 << (c == 7 ? 6 : c);
      t_run({5'b00001, c[2:0], 8'h00}, 1'b1, e, e, 48'h0);
    end
    report_and_stop;
  end
endmodule
